// >>> hw/rasr_defs.svh
// Register offsets, field positions and voltage scaling constants for the A-setting bank
`ifndef RASR_DEFS_SVH
`define RASR_DEFS_SVH
`define RASR_OFF_PROC 8'hA5
`define RASR_OFF_MEM 8'hA6
`define RASR_OFF_IO 8'hA7
`define RASR_OFF_PERI 8'hA8
`define RASR_OFF_RSVD1 8'hA9
`define RASR_OFF_RSVD2 8'hAA
`define RASR_OFF_LDO 8'hAB
`define RASR_SLEEP_BIT 7
`define RASR_CODE_MSB 6
`define RASR_RESET_VAL 8'h00
`define RASR_PROC_BASE_MV 16'h0212
`define RASR_PROC_STEP_MV 16'h000a
`define RASR_BUCK_BASE_MV 16'h0320
`define RASR_BUCK_STEP_MV 16'h0014
`define RASR_LDO_BASE_MV 16'h0384
`define RASR_LDO_STEP_MV 16'h0014
`define RASR_ADDR_LSB 2
`endif

// >>> hw/rasr_pkg.sv
// Types shared by the A-setting register bank
package rasr_pkg;
   typedef logic [7:0] rasr_reg_t;
   typedef logic [15:0] rasr_mv_t;
   typedef enum logic {rasr_sync_t_sync, rasr_sync_t_sleep} rasr_op_t;
endpackage

// >>> hw/rasr_conv_if.sv
// Bundle carrying one regulator's setting from the bank to its decoder
`timescale 1ns/100ps
interface rasr_conv_if;
   rasr_pkg::rasr_reg_t setting;
   logic sleep;
   rasr_pkg::rasr_mv_t millivolts;
   modport bank (output setting, input sleep, input millivolts);
   modport dec (input setting, output sleep, output millivolts);
endinterface

// >>> hw/rasr_decode.sv
// Turns one setting register into a sleep select and a target voltage in millivolts
`timescale 1ns/100ps
`include "rasr_defs.svh"
module rasr_decode #(
   parameter logic [15:0] BASE_MV = 16'h0320,
   parameter logic [15:0] STEP_MV = 16'h0014
) (
   rasr_conv_if.dec conv
);
   logic [6:0] code;
   assign code = conv.setting[`RASR_CODE_MSB:0];
   assign conv.sleep = conv.setting[`RASR_SLEEP_BIT];
   assign conv.millivolts = 16'(BASE_MV + STEP_MV * {9'h000, code});
endmodule

// >>> hw/rasr_regs.sv
// APB register bank holding the A settings of four bucks and one linear regulator
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "rasr_defs.svh"
module rasr_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [4:0] sleep_sel_a,
   output logic [6:0] processor_buck_voltage_code_a,
   output logic [6:0] memory_buck_voltage_code_a,
   output logic [6:0] io_buck_voltage_code_a,
   output logic [6:0] peripheral_buck_voltage_code_a,
   output logic [6:0] linear_reg_three_voltage_code_a,
   output logic [15:0] processor_buck_mv,
   output logic [15:0] memory_buck_mv,
   output logic [15:0] io_buck_mv,
   output logic [15:0] peripheral_buck_mv,
   output logic [15:0] linear_reg_three_mv
);
   localparam int NREG = 7;
   rasr_pkg::rasr_reg_t regs [NREG];
   logic [7:0] index;
   logic hit;
   logic wr_ok;
   logic rd_ok;
   logic [2:0] slot;
   rasr_pkg::rasr_reg_t next_rdata;

   // Printed offsets are register indices; byte address is four times the index
   assign index = paddr[9:2];
   assign hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00)
      && (index >= `RASR_OFF_PROC) && (index <= `RASR_OFF_LDO);
   assign slot = 3'(index - `RASR_OFF_PROC);
   assign wr_ok = psel && penable && pwrite && hit;
   assign rd_ok = psel && !penable && !pwrite && hit;

   always_comb begin
      next_rdata = 8'h00;
      if (hit) begin
         next_rdata = regs[slot];
      end
   end

   // Reserved slots are plain storage: written and read back, wired to nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NREG; i++) begin
            regs[i] <= `RASR_RESET_VAL;
         end
      end else if (wr_ok && pstrb[0]) begin
         regs[slot] <= pwdata[7:0];
      end
   end

   // Zero-wait slave: data captured in setup, answered in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_ok ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
      end
   end

   rasr_conv_if conv_proc ();
   rasr_conv_if conv_mem ();
   rasr_conv_if conv_io ();
   rasr_conv_if conv_peri ();
   rasr_conv_if conv_ldo ();
   assign conv_proc.setting = regs[0];
   assign conv_mem.setting = regs[1];
   assign conv_io.setting = regs[2];
   assign conv_peri.setting = regs[3];
   assign conv_ldo.setting = regs[6];

   rasr_decode #(.BASE_MV(`RASR_PROC_BASE_MV), .STEP_MV(`RASR_PROC_STEP_MV)) u_proc (.conv(conv_proc));
   rasr_decode #(.BASE_MV(`RASR_BUCK_BASE_MV), .STEP_MV(`RASR_BUCK_STEP_MV)) u_mem (.conv(conv_mem));
   rasr_decode #(.BASE_MV(`RASR_BUCK_BASE_MV), .STEP_MV(`RASR_BUCK_STEP_MV)) u_io (.conv(conv_io));
   rasr_decode #(.BASE_MV(`RASR_BUCK_BASE_MV), .STEP_MV(`RASR_BUCK_STEP_MV)) u_peri (.conv(conv_peri));
   rasr_decode #(.BASE_MV(`RASR_LDO_BASE_MV), .STEP_MV(`RASR_LDO_STEP_MV)) u_ldo (.conv(conv_ldo));

   // Outputs registered so the regulators see a clean, glitch-free setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_sel_a <= 5'h00;
      end else begin
         sleep_sel_a[0] <= conv_proc.sleep;
         sleep_sel_a[1] <= conv_mem.sleep;
         sleep_sel_a[2] <= conv_io.sleep;
         sleep_sel_a[3] <= conv_peri.sleep;
         sleep_sel_a[4] <= conv_ldo.sleep;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processor_buck_voltage_code_a <= 7'h00;
         memory_buck_voltage_code_a <= 7'h00;
         io_buck_voltage_code_a <= 7'h00;
         peripheral_buck_voltage_code_a <= 7'h00;
         linear_reg_three_voltage_code_a <= 7'h00;
      end else begin
         processor_buck_voltage_code_a <= regs[0][`RASR_CODE_MSB:0];
         memory_buck_voltage_code_a <= regs[1][`RASR_CODE_MSB:0];
         io_buck_voltage_code_a <= regs[2][`RASR_CODE_MSB:0];
         peripheral_buck_voltage_code_a <= regs[3][`RASR_CODE_MSB:0];
         linear_reg_three_voltage_code_a <= regs[6][`RASR_CODE_MSB:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processor_buck_mv <= `RASR_PROC_BASE_MV;
         memory_buck_mv <= `RASR_BUCK_BASE_MV;
         io_buck_mv <= `RASR_BUCK_BASE_MV;
         peripheral_buck_mv <= `RASR_BUCK_BASE_MV;
         linear_reg_three_mv <= `RASR_LDO_BASE_MV;
      end else begin
         processor_buck_mv <= conv_proc.millivolts;
         memory_buck_mv <= conv_mem.millivolts;
         io_buck_mv <= conv_io.millivolts;
         peripheral_buck_mv <= conv_peri.millivolts;
         linear_reg_three_mv <= conv_ldo.millivolts;
      end
   end
endmodule

// >>> verification/rasr_regs_monitor.sv
// Assertion checker for the A-setting register bank
`timescale 1ns/100ps
module rasr_regs_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [4:0] sleep_sel_a,
   input wire logic [6:0] processor_buck_voltage_code_a,
   input wire logic [15:0] processor_buck_mv
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   assign wr = psel && penable && pwrite && pstrb[0];
   // Decoded outputs update on the first edge after the write edge and are checked at the second
   a_proc_sleep_wr: assert property (wr && paddr == 12'h294 |=> ##1
      sleep_sel_a[0] == $past(pwdata[7], 2)) else $error("processor sleep select wrong");
   a_mem_sleep_wr: assert property (wr && paddr == 12'h298 |=> ##1
      sleep_sel_a[1] == $past(pwdata[7], 2)) else $error("memory sleep select wrong");
   a_io_sleep_wr: assert property (wr && paddr == 12'h29c |=> ##1
      sleep_sel_a[2] == $past(pwdata[7], 2)) else $error("io sleep select wrong");
   a_peri_sleep_wr: assert property (wr && paddr == 12'h2a0 |=> ##1
      sleep_sel_a[3] == $past(pwdata[7], 2)) else $error("peripheral sleep select wrong");
   a_ldo_sleep_wr: assert property (wr && paddr == 12'h2ac |=> ##1
      sleep_sel_a[4] == $past(pwdata[7], 2)) else $error("regulator sleep select wrong");
   a_proc_code_wr: assert property (wr && paddr == 12'h294 |=> ##1
      processor_buck_voltage_code_a == $past(pwdata[6:0], 2)) else $error("processor code wrong");
   a_proc_mv_scale: assert property (processor_buck_mv ==
      16'h0212 + 16'h000a * processor_buck_voltage_code_a) else $error("processor millivolts wrong");
   a_rsvd_no_effect: assert property (wr && (paddr == 12'h2a4 || paddr == 12'h2a8) |=>
      $stable(sleep_sel_a) && $stable(processor_buck_voltage_code_a)) else $error("reserved write leaked");
   c_proc_wr: cover property (wr && paddr == 12'h294);
   c_ldo_wr: cover property (wr && paddr == 12'h2ac);
   c_rsvd_wr: cover property (wr && paddr == 12'h2a4);
endmodule
bind rasr_regs rasr_regs_monitor i_mon (.*);

// >>> verification/test_regulator_a_setting_regs.sv
// Directed APB test of the A-setting register bank
`timescale 1ns/100ps
module test_regulator_a_setting_regs;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'h1;
   logic [4:0] sleep_sel_a;
   logic [6:0] c0, c1, c2, c3, c4;
   logic [15:0] m0, m1, m2, m3, m4;
   int num_errors = 0, comparisons = 0;
   rasr_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .sleep_sel_a, .processor_buck_voltage_code_a(c0), .memory_buck_voltage_code_a(c1),
      .io_buck_voltage_code_a(c2), .peripheral_buck_voltage_code_a(c3), .linear_reg_three_voltage_code_a(c4),
      .processor_buck_mv(m0), .memory_buck_mv(m1), .io_buck_mv(m2), .peripheral_buck_mv(m3),
      .linear_reg_three_mv(m4));
   task check(string n, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // An idle edge before each setup keeps the release and the next request apart
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Only the watchdog ends a wait that never sees pready
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task t_reset;
      for (int i = 0; i < 7; i++) begin
         apb(0, 12'h294 + 12'(4 * i), 0);
         check("reset", rd, 32'h0000_0000);
      end
   endtask
   task t_codes;
      for (int i = 0; i < 5; i++)
         apb(1, 12'h294 + 12'(4 * (i < 4 ? i : 6)), i < 4 ? 32'h0000_00ff : 32'h0000_00f1);
      apb(0, 12'h2ac, 0);
      check("ldo", rd, 32'h0000_00f1);
      check("sleep", sleep_sel_a, 5'h1f);
      check("c0", c0, 7'h7f);
      check("c1", c1, 7'h7f);
      check("c2", c2, 7'h7f);
      check("c3", c3, 7'h7f);
      check("m0", m0, 16'h0708);
      check("m1", m1, 16'h0d0c);
      check("m2", m2, 16'h0d0c);
      check("m3", m3, 16'h0d0c);
      check("c4", c4, 7'h71);
      check("m4", m4, 16'h0c58);
      apb(1, 12'h294, 0);
      apb(0, 12'h298, 0);
      check("mem", rd, 32'h0000_00ff);
      check("sleep", sleep_sel_a, 5'h1e);
      check("c0", c0, 7'h00);
      check("m0", m0, 16'h0212);
   endtask
   task t_rsvd;
      apb(1, 12'h2a4, 32'h0000_00ff);
      apb(1, 12'h2a8, 32'h0000_00aa);
      apb(0, 12'h2a8, 0);
      check("rsvd", rd, 32'h0000_00aa);
      check("sleep", sleep_sel_a, 5'h1e);
      check("m0", m0, 16'h0212);
      apb(0, 12'h2a4, 0);
      check("rsvd1", rd, 32'h0000_00ff);
      apb(0, 12'h2b0, 0);
      check("unmapped_err", err, 32'h0000_0001);
      check("unmapped_rd", rd, 32'h0000_0000);
   endtask
   task final_report;
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      #50000;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_codes();
      t_rsvd();
      final_report();
   end
endmodule
